// ---- dv/dual_mode_autoreload_timer_bench.sv ----
// self-checking bench for the auto-reload timer: register access, word and split counting, interrupts
// assumes the timer top with its wishbone slave; reads are noted in a queue and checked at ack
`include "timer_regs.svh"
`default_nettype none

module dual_mode_autoreload_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    string      what;
    logic [7:0] val;
    logic [7:0] msk;
    int         tol;
  } note_s;

  logic        clock_in;
  logic        reset_in;
  logic        wb_cyc_in;
  logic        wb_stb_in;
  logic        wb_we_in;
  logic [11:0] wb_adr_in;
  logic [3:0]  wb_sel_in;
  logic [31:0] wb_dat_in;
  logic [31:0] wb_dat_out;
  logic        wb_ack_out;
  logic        ext_clk_in;
  logic        irq_out;
  note_s       notes[$];
  int          err_total;
  int          n_checks;
  int          k;
  logic [31:0] lfsr_q;
  logic [7:0]  rl;
  logic [7:0]  rh;
  logic [9:0]  reg_tab [10] = '{`IDX_TIMER_CONTROL, `IDX_RELOAD_LOW, `IDX_RELOAD_HIGH, `IDX_COUNT_LOW,
    `IDX_COUNT_HIGH, `IDX_CLOCK_CONTROL, `IDX_EXT_IRQ_ENABLE, `IDX_IRQ_STATUS, `IDX_IRQ_MASK, 10'h3FF};
  logic [7:0]  ck_tab [3] = '{8'h03, 8'h01, 8'h01};
  logic [7:0]  ext_tab [3] = '{8'h01, 8'h00, 8'h01};
  logic [7:0]  exp_tab [3] = '{8'hEF, 8'h13, 8'h09};

  autoreload_timer autoreload_timer_i (
    .clock_in   (clock_in),
    .reset_in   (reset_in),
    .wb_cyc_in  (wb_cyc_in),
    .wb_stb_in  (wb_stb_in),
    .wb_we_in   (wb_we_in),
    .wb_adr_in  (wb_adr_in),
    .wb_sel_in  (wb_sel_in),
    .wb_dat_in  (wb_dat_in),
    .wb_dat_out (wb_dat_out),
    .wb_ack_out (wb_ack_out),
    .ext_clk_in (ext_clk_in),
    .irq_out    (irq_out)
  );

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic report_and_stop;
    if (err_total == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp_read(input note_s n, input logic [31:0] seen);
    logic [7:0] got;
    got = seen[7:0] & n.msk;
    n_checks++;
    if ((((got >= n.val) && (got <= n.val + n.tol) && (seen[31:8] == 24'h0)) !== 1'b1)) begin
      err_total++;
      $display("[FAIL] %s expected %h (+%0d) seen %h", n.what, n.val, n.tol, seen);
    end
  endtask

  task automatic cmp_irq(input logic exp);
    n_checks++;
    if (irq_out !== exp) begin
      err_total++;
      $display("[FAIL] irq_out expected %b seen %b", exp, irq_out);
    end
  endtask

  // one classic cycle; held until ack is sampled, then released for at least one cycle
  task automatic bus(input logic [9:0] idx, input logic we, input logic [7:0] d, input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge clock_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= {idx, 2'b00};
    wb_sel_in <= sel;
    wb_dat_in <= {24'h0, d};
    do begin
      @(posedge clock_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 50);
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in  <= 1'b0;
    if (n >= 50) begin
      err_total++;
      $display("[FAIL] bus ack expected 1 seen %b", wb_ack_out);
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d, 4'hF);
  endtask

  task automatic rd(input logic [9:0] idx, input string what, input logic [7:0] v, input logic [7:0] m, input int t);
    notes.push_back('{what, v, m, t});
    bus(idx, 1'b0, 8'h00, 4'hF);
  endtask

  // result watcher: every read ack consumes the oldest note
  always @(posedge clock_in) begin
    if (wb_ack_out === 1'b1 && wb_cyc_in === 1'b1 && wb_we_in === 1'b0) begin
      if (notes.size() == 0) begin
        err_total++;
        $display("[FAIL] read data expected none seen %h", wb_dat_out);
      end else begin
        cmp_read(notes.pop_front(), wb_dat_out);
      end
    end
  end

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // external oscillator: one rise every three system cycles, changed on the edge by nba to avoid a race
  initial begin
    ext_clk_in = 1'b0;
    forever begin
      repeat (2) @(posedge clock_in);
      ext_clk_in <= 1'b1;
      @(posedge clock_in);
      ext_clk_in <= 1'b0;
    end
  end

  initial begin
    repeat (20000) @(posedge clock_in);
    err_total++;
    $display("[FAIL] run length expected done seen timeout");
    report_and_stop();
  end

  initial begin
    lfsr_q    = 32'hDE12;
    err_total = 0;
    n_checks  = 0;
    reset_in  = 1'b1;
    wb_cyc_in = 1'b0;
    wb_stb_in = 1'b0;
    wb_we_in  = 1'b0;
    wb_adr_in = 12'h000;
    wb_sel_in = 4'h0;
    wb_dat_in = 32'h0;
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    for (k = 0; k < 10; k++) rd(reg_tab[k], "reset value", 8'h00, 8'hFF, 0);
    bus(`IDX_RELOAD_LOW, 1'b1, 8'hA5, 4'hE);
    rd(`IDX_RELOAD_LOW, "write without lane 0", 8'h00, 8'hFF, 0);
    wr(10'h3FF, 8'hFF);
    rd(10'h3FF, "unmapped", 8'h00, 8'hFF, 0);
    for (k = 1; k < 5; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      wr(reg_tab[k], lfsr_q[7:0]);
      rd(reg_tab[k], "byte register", lfsr_q[7:0], 8'hFF, 0);
    end
    // word wrap with a few system clock ticks
    lfsr_q = lfsr_next(lfsr_q);
    rh = lfsr_q[15:8];
    wr(`IDX_RELOAD_LOW, 8'h00);
    wr(`IDX_RELOAD_HIGH, rh);
    wr(`IDX_COUNT_LOW, 8'hFF);
    wr(`IDX_COUNT_HIGH, 8'hFF);
    wr(`IDX_CLOCK_CONTROL, 8'h03);
    wr(`IDX_TIMER_CONTROL, 8'h04);
    wr(`IDX_TIMER_CONTROL, 8'hC0);
    rd(`IDX_COUNT_HIGH, "count high after wrap", rh, 8'hFF, 0);
    rd(`IDX_COUNT_LOW, "count low after wrap", 8'h00, 8'hF0, 0);
    rd(`IDX_TIMER_CONTROL, "flags after word wrap", 8'hC0, 8'hC0, 0);
    cmp_irq(1'b0);
    wr(`IDX_IRQ_MASK, 8'h03);
    repeat (2) @(posedge clock_in);
    cmp_irq(1'b1);
    rd(`IDX_IRQ_STATUS, "irq status", 8'h03, 8'hFF, 0);
    repeat (2) @(posedge clock_in);
    cmp_irq(1'b0);
    rd(`IDX_IRQ_STATUS, "irq status after read", 8'h00, 8'hFF, 0);
    wr(`IDX_IRQ_MASK, 8'h00);
    wr(`IDX_EXT_IRQ_ENABLE, 8'h80);
    repeat (2) @(posedge clock_in);
    cmp_irq(1'b1);
    wr(`IDX_TIMER_CONTROL, 8'h00);
    repeat (2) @(posedge clock_in);
    cmp_irq(1'b0);
    wr(`IDX_COUNT_LOW, 8'hFF);
    wr(`IDX_COUNT_HIGH, 8'h00);
    wr(`IDX_TIMER_CONTROL, 8'h24);
    wr(`IDX_TIMER_CONTROL, 8'h60);
    rd(`IDX_TIMER_CONTROL, "flags after low wrap", 8'h60, 8'hE0, 0);
    cmp_irq(1'b1);
    wr(`IDX_TIMER_CONTROL, 8'h40);
    repeat (2) @(posedge clock_in);
    cmp_irq(1'b0);
    // split mode: low byte free running, high byte gated
    lfsr_q = lfsr_next(lfsr_q);
    rh = {lfsr_q[7:4], 4'h0};
    rl = lfsr_q[15:8];
    wr(`IDX_RELOAD_LOW, rl);
    wr(`IDX_RELOAD_HIGH, rh);
    wr(`IDX_COUNT_HIGH, 8'hFF);
    wr(`IDX_COUNT_LOW, 8'hFF);
    wr(`IDX_TIMER_CONTROL, 8'h08);
    rd(`IDX_COUNT_HIGH, "high held while stopped", 8'hFF, 8'hFF, 0);
    rd(`IDX_TIMER_CONTROL, "flags split stopped", 8'h48, 8'hC8, 0);
    cmp_irq(1'b0);
    wr(`IDX_TIMER_CONTROL, 8'h0C);
    wr(`IDX_TIMER_CONTROL, 8'h88);
    rd(`IDX_COUNT_HIGH, "high reload split", rh, 8'hF0, 0);
    rd(`IDX_TIMER_CONTROL, "high flag split", 8'h80, 8'h80, 0);
    cmp_irq(1'b1);
    wr(`IDX_TIMER_CONTROL, 8'h28);
    // irq_out still shows the cleared high flag for one edge
    repeat (2) @(posedge clock_in);
    k = 0;
    while (irq_out !== 1'b1 && k < 300) begin
      @(posedge clock_in);
      k++;
    end
    cmp_irq(1'b1);
    rd(`IDX_TIMER_CONTROL, "low flag only", 8'h40, 8'hC0, 0);
    // high byte counted over a fixed window from each source
    wr(`IDX_RELOAD_HIGH, 8'h00);
    for (k = 0; k < 3; k++) begin
      wr(`IDX_CLOCK_CONTROL, ck_tab[k]);
      wr(`IDX_COUNT_HIGH, 8'h00);
      wr(`IDX_TIMER_CONTROL, 8'h0C | ext_tab[k]);
      repeat (237) @(posedge clock_in);
      wr(`IDX_TIMER_CONTROL, 8'h08 | ext_tab[k]);
      rd(`IDX_COUNT_HIGH, "split high clock source", exp_tab[k], 8'hFF, 2);
    end
    report_and_stop();
  end
endmodule

`default_nettype wire

// ---- src/autoreload_timer.sv ----
// 16-bit auto-reload timer with split 8-bit mode and a classic wishbone register slave
// assumes one system clock; ext_clk_in is a plain input sampled on clock_in
// Function
// (R1) count is 16 bits held in separately addressed low and high byte registers
// (R2) split bit clear: one 16-bit counter with auto-reload
// (R3) count source: system clock, system clock / 12, or synchronized external clock / 8
// (R4) 16-bit wrap from all ones loads both reload bytes and sets high flag
// (R5) timer interrupt enable makes every 16-bit overflow request an interrupt
// (R6) in 16-bit mode, low-byte irq enable also interrupts on each low wrap
// (R7) split mode: two 8-bit counters, each reloading from its own reload byte
// (R8) split mode: run bit gates only the high byte; low byte always counts
// (R9) per-byte select 1 uses system clock, else external select picks /12 or /8
// (R10) split mode: each byte wrap from 0xFF sets that byte's overflow flag
// (R11) split mode: high wraps always interrupt, low wraps when low irq enable set; the code also needs timer_ie_q set for both
// (R12) overflow flags stay set until software writes them clear
// (R13) software reads both flags to find which byte interrupted
// (R14) low flag sets on every low-byte wrap in either mode
// (R15) count and reload bytes are readable and writable at any time
`include "timer_regs.svh"
`default_nettype none

module autoreload_timer (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  // wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [11:0] wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // external oscillator
  input  wire logic        ext_clk_in,
  // interrupt
  output logic             irq_out
);
  tick_if ticks ();

  clk_tick_gen clk_tick_gen_i (
    .clock_in   (clock_in),
    .reset_in   (reset_in),
    .ext_clk_in (ext_clk_in),
    .ticks      (ticks.src)
  );

  timer_pkg::byte_t       count_low_q;
  timer_pkg::byte_t       count_high_q;
  timer_pkg::byte_t       reload_low_q;
  timer_pkg::byte_t       reload_high_q;
  timer_pkg::byte_t       count_low_d;
  timer_pkg::byte_t       count_high_d;
  logic                   high_flag_q;
  logic                   low_flag_q;
  logic                   low_irq_en_q;
  logic                   split_q;
  logic                   run_q;
  logic                   ext_sel_q;
  logic                   low_clk_sel_q;
  logic                   high_clk_sel_q;
  logic                   timer_ie_q;
  logic [1:0]             irq_status_q;
  logic [1:0]             irq_mask_q;
  logic                   ack_q;
  logic [31:0]            dat_q;
  logic                   irq_q;
  timer_pkg::count_mode_e mode;

  // bus decode: the access completes on the edge where ack is high
  wire        access    = wb_cyc_in & wb_stb_in & ack_q;
  wire        wr        = access & wb_we_in & wb_sel_in[0];
  wire        rd        = access & ~wb_we_in;
  wire [9:0]  idx       = wb_adr_in[11:2];
  wire [7:0]  wdat      = wb_dat_in[7:0];
  wire        hit_ctrl  = (idx == `IDX_TIMER_CONTROL);
  wire        hit_rll   = (idx == `IDX_RELOAD_LOW);
  wire        hit_rlh   = (idx == `IDX_RELOAD_HIGH);
  wire        hit_cl    = (idx == `IDX_COUNT_LOW);
  wire        hit_ch    = (idx == `IDX_COUNT_HIGH);
  wire        hit_ckc   = (idx == `IDX_CLOCK_CONTROL);
  wire        hit_eie   = (idx == `IDX_EXT_IRQ_ENABLE);
  wire        hit_ist   = (idx == `IDX_IRQ_STATUS);
  wire        hit_imask = (idx == `IDX_IRQ_MASK);
  wire        wr_ctrl   = wr & hit_ctrl;
  wire        wr_cl     = wr & hit_cl;
  wire        wr_ch     = wr & hit_ch;
  wire        rd_ist    = rd & hit_ist;

  assign mode = timer_pkg::count_mode_e'(split_q);
  wire split = (mode == timer_pkg::MODE_SPLIT);

  // per-byte source; in 16-bit mode the whole word follows the low-byte select
  wire slow_tick = ext_sel_q ? ticks.tick_ext8 : ticks.tick_div12;  // [R3] [R9]
  wire tick_low  = low_clk_sel_q | slow_tick;                        // [R9]
  wire tick_high = high_clk_sel_q | slow_tick;                       // [R9]

  // low byte free-runs in split mode; run gates the high byte or the word
  wire adv_low   = split ? tick_low : (run_q & tick_low);            // [R2] [R8]
  wire adv_high  = run_q & tick_high;                                // [R8]
  wire wrap_low  = adv_low & (count_low_q == `BYTE_MAX);             // [R14]
  wire wrap_word = ~split & wrap_low & (count_high_q == `BYTE_MAX);  // [R4]
  wire wrap_high = split ? (adv_high & (count_high_q == `BYTE_MAX)) : wrap_word; // [R10]

  // software writes win over counting
  always_comb begin
    if (wr_cl) begin
      count_low_d = wdat;                                            // [R15]
    end else if (!adv_low) begin
      count_low_d = count_low_q;
    end else if (!wrap_low) begin
      count_low_d = count_low_q + `BYTE_ONE;                         // [R2]
    end else if (split || wrap_word) begin
      count_low_d = reload_low_q;                                    // [R4] [R7]
    end else begin
      count_low_d = `BYTE_ZERO;
    end
  end

  always_comb begin
    if (wr_ch) begin
      count_high_d = wdat;                                           // [R15]
    end else if (split) begin
      if (!adv_high) begin
        count_high_d = count_high_q;                                 // [R8]
      end else if (wrap_high) begin
        count_high_d = reload_high_q;                                // [R7]
      end else begin
        count_high_d = count_high_q + `BYTE_ONE;
      end
    end else if (!wrap_low) begin
      count_high_d = count_high_q;
    end else if (wrap_word) begin
      count_high_d = reload_high_q;                                  // [R4]
    end else begin
      count_high_d = count_high_q + `BYTE_ONE;                       // [R2]
    end
  end

  // hardware set wins over a software clear in the same cycle
  wire high_flag_d = (wr_ctrl ? wdat[`CTRL_HIGH_FLAG] : high_flag_q) | wrap_high; // [R4] [R10] [R12]
  wire low_flag_d  = (wr_ctrl ? wdat[`CTRL_LOW_FLAG] : low_flag_q) | wrap_low;    // [R10] [R12] [R14]
  wire [1:0] irq_status_d = (rd_ist ? `IST_ZERO : irq_status_q) | {wrap_low, wrap_high};

  // flags alone drive the documented request; status/mask adds a second path
  wire irq_d = (timer_ie_q & (high_flag_q | (low_irq_en_q & low_flag_q)))    // [R5] [R6] [R11]
             | (|(irq_status_q & irq_mask_q));

  wire [7:0] ctrl_rd = {high_flag_q, low_flag_q, low_irq_en_q, 1'b0, split_q, run_q, 1'b0, ext_sel_q};
  wire [31:0] rdata =
    hit_ctrl  ? {24'h000000, ctrl_rd} :
    hit_rll   ? {24'h000000, reload_low_q} :
    hit_rlh   ? {24'h000000, reload_high_q} :
    hit_cl    ? {24'h000000, count_low_q} :                          // [R1]
    hit_ch    ? {24'h000000, count_high_q} :                         // [R1]
    hit_ckc   ? {30'h0, high_clk_sel_q, low_clk_sel_q} :
    hit_eie   ? {24'h000000, timer_ie_q, 7'h00} :
    hit_ist   ? {30'h0, irq_status_q} :
    hit_imask ? {30'h0, irq_mask_q} : `WORD_ZERO;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      count_low_q  <= `BYTE_ZERO;
      count_high_q <= `BYTE_ZERO;
      high_flag_q  <= 1'b0;
      low_flag_q   <= 1'b0;
      irq_status_q <= `IST_ZERO;
    end else begin
      count_low_q  <= count_low_d;
      count_high_q <= count_high_d;
      high_flag_q  <= high_flag_d;
      low_flag_q   <= low_flag_d;
      irq_status_q <= irq_status_d;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      reload_low_q  <= `BYTE_ZERO;
      reload_high_q <= `BYTE_ZERO;
    end else begin
      if (wr && hit_rll) reload_low_q <= wdat;                       // [R15]
      if (wr && hit_rlh) reload_high_q <= wdat;                      // [R15]
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      low_irq_en_q <= 1'b0;
      split_q      <= 1'b0;
      run_q        <= 1'b0;
      ext_sel_q    <= 1'b0;
    end else if (wr_ctrl) begin
      low_irq_en_q <= wdat[`CTRL_LOW_IRQ_EN];
      split_q      <= wdat[`CTRL_SPLIT];
      run_q        <= wdat[`CTRL_RUN];
      ext_sel_q    <= wdat[`CTRL_EXT_SEL];
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      low_clk_sel_q  <= 1'b0;
      high_clk_sel_q <= 1'b0;
      timer_ie_q     <= 1'b0;
      irq_mask_q     <= `IST_ZERO;
    end else begin
      if (wr && hit_ckc) low_clk_sel_q <= wdat[`CKC_LOW_SEL];
      if (wr && hit_ckc) high_clk_sel_q <= wdat[`CKC_HIGH_SEL];
      if (wr && hit_eie) timer_ie_q <= wdat[`EIE_TIMER];
      if (wr && hit_imask) irq_mask_q <= wdat[1:0];
    end
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      ack_q <= 1'b0;
      dat_q <= `WORD_ZERO;
      irq_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_in & wb_stb_in & ~ack_q;
      dat_q <= (wb_cyc_in & wb_stb_in & ~ack_q) ? rdata : dat_q;
      irq_q <= irq_d;
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = dat_q;
  assign irq_out    = irq_q;

  property p_byte_write;
    @(posedge clock_in) disable iff (reset_in)
    (wr_cl && !wrap_low && !(split && adv_high)) |=>
      (count_low_q == $past(wdat)) && (count_high_q == $past(count_high_q));
  endproperty
  a_byte_write: assert property (p_byte_write) // [R1]
    else $error("low count write not taken alone");

  property p_word_inc;
    @(posedge clock_in) disable iff (reset_in)
    (!split && adv_low && !wrap_low && !wr_cl && !wr_ch) |=>
      ({count_high_q, count_low_q} == $past({count_high_q, count_low_q}) + 16'h0001);
  endproperty
  a_word_inc: assert property (p_word_inc) // [R2]
    else $error("16-bit count did not advance by one");

  property p_word_reload;
    @(posedge clock_in) disable iff (reset_in)
    (wrap_word && !wr_cl && !wr_ch) |=>
      (count_low_q == $past(reload_low_q)) && (count_high_q == $past(reload_high_q)) && high_flag_q;
  endproperty
  a_word_reload: assert property (p_word_reload) // [R4]
    else $error("16-bit overflow did not reload and flag");

  property p_irq_high;
    @(posedge clock_in) disable iff (reset_in)
    (timer_ie_q && high_flag_q) |=> irq_out;
  endproperty
  a_irq_high: assert property (p_irq_high) // [R5]
    else $error("high overflow with interrupt enabled gave no interrupt");

  property p_irq_low;
    @(posedge clock_in) disable iff (reset_in)
    (timer_ie_q && low_irq_en_q && low_flag_q) |=> irq_out;
  endproperty
  a_irq_low: assert property (p_irq_low) // [R6]
    else $error("low overflow with both enables gave no interrupt");

  property p_split_low_reload;
    @(posedge clock_in) disable iff (reset_in)
    (split && wrap_low && !wr_cl) |=> (count_low_q == $past(reload_low_q)) && low_flag_q;
  endproperty
  a_split_low_reload: assert property (p_split_low_reload) // [R7]
    else $error("split low byte did not reload from its reload byte");

  property p_split_high_hold;
    @(posedge clock_in) disable iff (reset_in)
    (split && !run_q && !wr_ch) |=> $stable(count_high_q);
  endproperty
  a_split_high_hold: assert property (p_split_high_hold) // [R8]
    else $error("split high byte moved while stopped");

  property p_split_high_fast;
    @(posedge clock_in) disable iff (reset_in)
    (split && run_q && high_clk_sel_q && !wr_ch && count_high_q != `BYTE_MAX) |=>
      (count_high_q == $past(count_high_q) + `BYTE_ONE);
  endproperty
  a_split_high_fast: assert property (p_split_high_fast) // [R9]
    else $error("high byte on system clock did not count every cycle");

  property p_split_high_flag;
    @(posedge clock_in) disable iff (reset_in)
    (split && wrap_high) |=> high_flag_q;
  endproperty
  a_split_high_flag: assert property (p_split_high_flag) // [R10]
    else $error("split high wrap did not set high flag");

  property p_flag_sticky;
    @(posedge clock_in) disable iff (reset_in)
    (high_flag_q && !wr_ctrl) |=> high_flag_q;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) // [R12]
    else $error("high flag cleared without a software write");

  property p_word_low_flag;
    @(posedge clock_in) disable iff (reset_in)
    (!split && wrap_low) |=> low_flag_q;
  endproperty
  a_word_low_flag: assert property (p_word_low_flag) // [R14]
    else $error("low wrap in 16-bit mode did not set low flag");

endmodule

`default_nettype wire

// ---- src/clk_tick_gen.sv ----
// one-cycle count enables: system clock / 12 and external clock / 8
// assumes ext_clk_in is far slower than clock_in (under half its rate)
`include "timer_regs.svh"
`default_nettype none

module clk_tick_gen (
  // clock and reset
  input  wire logic clock_in,
  input  wire logic reset_in,
  // external oscillator
  input  wire logic ext_clk_in,
  // enables
  tick_if.src       ticks
);
  logic [3:0] sys_cnt_q;
  logic [2:0] ext_cnt_q;
  logic       sync1_q;
  logic       sync2_q;
  logic       sync3_q;
  logic       div12_q;
  logic       ext8_q;
  wire        sys_last = (sys_cnt_q == `DIV_SYS_LAST);
  wire        ext_rise = sync2_q & ~sync3_q;
  wire        ext_last = ext_rise & (ext_cnt_q == `DIV_EXT_LAST);

  // external edges are brought onto the system clock before counting [R3]
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= ext_clk_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      sys_cnt_q <= `DIV_SYS_ZERO;
      ext_cnt_q <= `DIV_EXT_ZERO;
      div12_q   <= 1'b0;
      ext8_q    <= 1'b0;
    end else begin
      sys_cnt_q <= sys_last ? `DIV_SYS_ZERO : sys_cnt_q + `DIV_SYS_ONE; // [R3]
      ext_cnt_q <= ext_rise ? ext_cnt_q + `DIV_EXT_ONE : ext_cnt_q;      // [R3]
      div12_q   <= sys_last;
      ext8_q    <= ext_last;
    end
  end

  assign ticks.tick_div12 = div12_q;
  assign ticks.tick_ext8  = ext8_q;

  property p_div12_period;
    @(posedge clock_in) disable iff (reset_in)
    div12_q |-> ##1 (!div12_q) [*8] ##1 (!div12_q) [*3] ##1 div12_q;
  endproperty
  a_div12_period: assert property (p_div12_period) // [R3]
    else $error("system clock divide by 12 tick period wrong");

  property p_ext8_spacing;
    @(posedge clock_in) disable iff (reset_in)
    ext8_q |=> !ext8_q;
  endproperty
  a_ext8_spacing: assert property (p_ext8_spacing) // [R3]
    else $error("external divide by 8 tick lasted more than one cycle");

endmodule

`default_nettype wire

// ---- src/tick_if.sv ----
// prescaled count enables passed from the tick generator to the timer core
// assumes both ends run on the same system clock
`default_nettype none

interface tick_if;
  logic tick_div12;
  logic tick_ext8;
  modport src (output tick_div12, output tick_ext8);
  modport snk (input tick_div12, input tick_ext8);
endinterface

`default_nettype wire

// ---- src/timer_pkg.sv ----
// types shared by the timer files
// assumes nothing beyond a systemverilog compiler
`default_nettype none

package timer_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic {
    MODE_WORD  = 1'b0,
    MODE_SPLIT = 1'b1
  } count_mode_e;
endpackage

`default_nettype wire

// ---- src/timer_regs.svh ----
// register map, field positions, reset values and timing counts of the auto-reload timer
// assumes a 32-bit classic wishbone slave, one register per aligned word, byte address = index * 4
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// register indices; the byte address is four times the index
`define IDX_TIMER_CONTROL    10'h091
`define IDX_RELOAD_LOW       10'h092
`define IDX_RELOAD_HIGH      10'h093
`define IDX_COUNT_LOW        10'h094
`define IDX_COUNT_HIGH       10'h095
`define IDX_CLOCK_CONTROL    10'h08E
`define IDX_EXT_IRQ_ENABLE   10'h0E6
`define IDX_IRQ_STATUS       10'h0A0
`define IDX_IRQ_MASK         10'h0A1

// timer_control_reg fields
`define CTRL_HIGH_FLAG       7
`define CTRL_LOW_FLAG        6
`define CTRL_LOW_IRQ_EN      5
`define CTRL_SPLIT           3
`define CTRL_RUN             2
`define CTRL_EXT_SEL         0

// clock_control_reg fields
`define CKC_LOW_SEL          0
`define CKC_HIGH_SEL         1

// ext_irq_enable_reg field
`define EIE_TIMER            7

// irq status / mask fields
`define IST_HIGH             0
`define IST_LOW              1

// values
`define BYTE_ZERO            8'h00
`define BYTE_ONE             8'h01
`define BYTE_MAX             8'hFF
`define WORD_ZERO            32'h0000_0000
`define IST_ZERO             2'h0

// prescalers
`define DIV_SYS_LAST         4'hB
`define DIV_SYS_ONE          4'h1
`define DIV_SYS_ZERO         4'h0
`define DIV_EXT_LAST         3'h7
`define DIV_EXT_ONE          3'h1
`define DIV_EXT_ZERO         3'h0

`endif
